// ---- hdl/rtc_host_end.sv ----
// Host end of the multiplexed RTC bus.
// Assumes single requests from user logic, one at a time.
`timescale 1ns/10ps
`include "rtc_params.svh"
module rtc_host_end (
    input  wire logic               mclk,
    input  wire logic               rst,
    rtc_bus_if.host                 bus,
    input  wire logic               req_valid,
    output logic                    req_ready,
    input  wire logic               req_write,
    input  wire rtc_pkg::rtc_byte_t req_addr,
    input  wire rtc_pkg::rtc_byte_t req_wdata,
    output logic                    rsp_valid,
    output rtc_pkg::rtc_byte_t      rsp_rdata,
    output logic                    pwr_active
);
    localparam logic [7:0] ALE_CYC   = 8'(`RTC_ALE_CYC);
    localparam logic [7:0] AHOLD_CYC = 8'(`RTC_AHOLD_CYC);
    localparam logic [7:0] STRB_CYC  = 8'(`RTC_STRB_CYC);
    localparam logic [7:0] RECOV_CYC = 8'(`RTC_RECOV_CYC);

    rtc_pkg::rtc_hstate_t state_r, state_nxt;  // Cycle phase
    logic [7:0]           cnt_r, cnt_nxt;      // Cycles left in phase
    logic                 wr_r, wr_nxt;        // Cycle is a write
    rtc_pkg::rtc_byte_t   addr_r, addr_nxt;    // Latched address
    rtc_pkg::rtc_byte_t   wdat_r, wdat_nxt;    // Write data
    rtc_pkg::rtc_byte_t   rdat_r, rdat_nxt;    // Read data
    logic                 rsp_r, rsp_nxt;      // Answer pulse
    logic                 pwr_r, pwr_nxt;      // Power pin seen low

    // Accept only when idle
    assign req_ready = (state_r == rtc_pkg::RTC_H_IDLE);

    // Phase sequencing
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        wr_nxt    = wr_r;
        addr_nxt  = addr_r;
        wdat_nxt  = wdat_r;
        rdat_nxt  = rdat_r;
        rsp_nxt   = 1'b0;
        pwr_nxt   = ~bus.power_on_out_n;
        case (state_r)
            rtc_pkg::RTC_H_IDLE: begin
                // Take a request
                if (req_valid) begin
                    state_nxt = rtc_pkg::RTC_H_ADDR;
                    cnt_nxt   = ALE_CYC - 8'h01;
                    wr_nxt    = req_write;
                    addr_nxt  = req_addr;
                    wdat_nxt  = req_wdata;
                end
            end
            rtc_pkg::RTC_H_ADDR: begin
                if (cnt_r == 8'h00) begin
                    state_nxt = rtc_pkg::RTC_H_AHOLD;
                    cnt_nxt   = AHOLD_CYC - 8'h01;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            rtc_pkg::RTC_H_AHOLD: begin
                // Address held past falling edge
                if (cnt_r == 8'h00) begin
                    state_nxt = rtc_pkg::RTC_H_STRB;
                    cnt_nxt   = STRB_CYC - 8'h01;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            rtc_pkg::RTC_H_STRB: begin
                // Capture read data at strobe end
                if (cnt_r == 8'h00) begin
                    state_nxt = rtc_pkg::RTC_H_RECOV;
                    cnt_nxt   = RECOV_CYC - 8'h01;
                    rsp_nxt   = 1'b1;
                    if (!wr_r) begin
                        rdat_nxt = bus.shared_addr_data_bus;
                    end
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            rtc_pkg::RTC_H_RECOV: begin
                // Idle bus before next cycle
                if (cnt_r == 8'h00) begin
                    state_nxt = rtc_pkg::RTC_H_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            default: begin
                state_nxt = rtc_pkg::RTC_H_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= rtc_pkg::RTC_H_IDLE;
            cnt_r   <= 8'h00;
            wr_r    <= 1'b0;
            addr_r  <= 8'h00;
            wdat_r  <= 8'h00;
            rdat_r  <= 8'h00;
            rsp_r   <= 1'b0;
            pwr_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            wr_r    <= wr_nxt;
            addr_r  <= addr_nxt;
            wdat_r  <= wdat_nxt;
            rdat_r  <= rdat_nxt;
            rsp_r   <= rsp_nxt;
            pwr_r   <= pwr_nxt;
        end
    end

    // Pin drive from phase
    always_comb begin
        bus.host_ad_out = (state_r == rtc_pkg::RTC_H_STRB) ? wdat_r : addr_r;
        bus.host_ad_oe  = (state_r == rtc_pkg::RTC_H_ADDR) || (state_r == rtc_pkg::RTC_H_AHOLD) ||
                          ((state_r == rtc_pkg::RTC_H_STRB) && wr_r);
        bus.ale         = (state_r == rtc_pkg::RTC_H_ADDR);
        bus.cs_n        = (state_r != rtc_pkg::RTC_H_STRB);
        // only one strobe at a time
        bus.rd_n        = !((state_r == rtc_pkg::RTC_H_STRB) && !wr_r);
        bus.wr_n        = !((state_r == rtc_pkg::RTC_H_STRB) && wr_r);
    end

    assign rsp_valid  = rsp_r;
    assign rsp_rdata  = rdat_r;
    assign pwr_active = pwr_r;
endmodule : rtc_host_end

// ---- hdl/rtc_params.svh ----
// Constants shared by both ends of the multiplexed RTC bus.
// Assumes one 125 MHz clock and inputs synchronous to it.
// Behaviour
// - Open-drain active-low power output, pulls only
// - Without main supply, kickstart or alarm raise power
// - With supply, power level follows control bit
// - Control bit selects 6pF or 12.5pF crystal
// - Shared lines carry address then data
// - Host sets address before address strobe ends
// - Host holds write data through strobe end
// - Device drives 8 data bits during read
// - Device releases bus when read ends
// - Extended RAM uses the same bus cycles
// - Memory fetch overlaps address-to-data turnaround
// - Address latched on address strobe falling edge
// - Host keeps select low through strobes
// - Unselected cycle latches address, moves no data
// - Writes happen only while write strobe low
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// Bus and memory geometry
`define RTC_BUS_W          8
`define RTC_MEM_DEPTH      256
// Extended control register and its fields
`define RTC_EXT_CTRL_ADDR  8'h4B
`define RTC_EXT_CTRL_RST   8'h00
`define RTC_XTAL_SEL_BIT   6
`define RTC_PWR_KEEP_BIT   0
// Clock rate
`define RTC_CLK_MHZ        125
`define RTC_CLK_PERIOD_NS  (1000 / `RTC_CLK_MHZ)
// Host strobe timing in ns, least times
`define RTC_ALE_PULSE_NS   40
`define RTC_ADDR_HOLD_NS   16
`define RTC_STRB_PULSE_NS  160
`define RTC_RECOV_NS       24
// Cycle counts, rounded up
`define RTC_ALE_CYC   ((`RTC_ALE_PULSE_NS + `RTC_CLK_PERIOD_NS - 1) / `RTC_CLK_PERIOD_NS)
`define RTC_AHOLD_CYC ((`RTC_ADDR_HOLD_NS + `RTC_CLK_PERIOD_NS - 1) / `RTC_CLK_PERIOD_NS)
`define RTC_STRB_CYC  ((`RTC_STRB_PULSE_NS + `RTC_CLK_PERIOD_NS - 1) / `RTC_CLK_PERIOD_NS)
`define RTC_RECOV_CYC ((`RTC_RECOV_NS + `RTC_CLK_PERIOD_NS - 1) / `RTC_CLK_PERIOD_NS)

`endif

// ---- hdl/rtc_pkg.sv ----
// Types shared by both ends of the multiplexed RTC bus.
// Assumes the constants header is included by users.
package rtc_pkg;

    // One bus byte
    typedef logic [7:0] rtc_byte_t;

    // Host bus cycle phases
    typedef enum logic [2:0] {
        RTC_H_IDLE,
        RTC_H_ADDR,
        RTC_H_AHOLD,
        RTC_H_STRB,
        RTC_H_RECOV
    } rtc_hstate_t;

endpackage : rtc_pkg

// ---- hdl/rtc_bus_if.sv ----
// Pin-level carrier between host end and device end.
// Resolves the shared bus and the open-drain power pin.
`timescale 1ns/10ps
interface rtc_bus_if;
    // Host drive of shared lines
    rtc_pkg::rtc_byte_t host_ad_out;
    logic               host_ad_oe;
    // Device drive of shared lines
    rtc_pkg::rtc_byte_t dev_ad_out;
    logic               dev_ad_oe;
    // Strobes from host
    logic               ale;
    logic               cs_n;
    logic               rd_n;
    logic               wr_n;
    // Open-drain power pin drive
    logic               pwr_out;
    logic               pwr_oe;
    // Resolved wire levels
    rtc_pkg::rtc_byte_t shared_addr_data_bus;
    logic               power_on_out_n;

    // Bus level, pull-up when nobody drives
    assign shared_addr_data_bus = dev_ad_oe  ? dev_ad_out  :
                                  host_ad_oe ? host_ad_out : 8'hFF;
    // Pull-up unless pulled low
    assign power_on_out_n = pwr_oe ? pwr_out : 1'b1;

    // Host side
    modport host (
        output host_ad_out,
        output host_ad_oe,
        output ale,
        output cs_n,
        output rd_n,
        output wr_n,
        input  shared_addr_data_bus,
        input  power_on_out_n
    );

    // Device side
    modport dev (
        output dev_ad_out,
        output dev_ad_oe,
        output pwr_out,
        output pwr_oe,
        input  ale,
        input  cs_n,
        input  rd_n,
        input  wr_n,
        input  shared_addr_data_bus
    );
endinterface : rtc_bus_if

// ---- hdl/rtc_dev_end.sv ----
// Device end of the multiplexed RTC bus with power control.
// Assumes strobes synchronous to mclk and a single host.
`timescale 1ns/10ps
`include "rtc_params.svh"
module rtc_dev_end #(
    parameter int MEM_DEPTH = `RTC_MEM_DEPTH
) (
    input  wire logic mclk,
    input  wire logic rst,
    rtc_bus_if.dev    bus,
    input  wire logic vcc_present,
    input  wire logic kickstart_in_n,
    input  wire logic wake_alarm,
    input  wire logic crystal_in,
    output logic      crystal_out,
    output logic      xtal_load_sel,
    output logic      pwr_on_state
);
    localparam int AW = $clog2(MEM_DEPTH);

    rtc_pkg::rtc_byte_t mem [MEM_DEPTH];         // Clock registers and extended RAM

    // Address latch group
    logic               ale_d_r, ale_d_nxt;      // Strobe level last cycle
    rtc_pkg::rtc_byte_t addr_r, addr_nxt;        // Latched address
    logic               ale_fall;                // Strobe falling edge

    // Write group
    logic               mem_we;                  // Memory write this cycle
    logic               bus_wr;                  // Selected write strobe

    // Read group
    rtc_pkg::rtc_byte_t rdat_r, rdat_nxt;        // Prefetched read byte

    // Control group
    rtc_pkg::rtc_byte_t ctrl_r, ctrl_nxt;        // Extended control register
    logic               pwr_r, pwr_nxt;          // Power pin pulled low
    logic               wake_evt;                // Kickstart or alarm seen
    logic               xout_r, xout_nxt;        // Oscillator output drive

    assign ale_fall = ale_d_r && !bus.ale;

    // Address latch next values
    always_comb begin
        ale_d_nxt = bus.ale;
        addr_nxt  = addr_r;
        if (ale_fall) begin
            addr_nxt = bus.shared_addr_data_bus;
        end
    end

    // Address latch registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            ale_d_r <= 1'b0;
            addr_r  <= 8'h00;
        end else begin
            ale_d_r <= ale_d_nxt;
            addr_r  <= addr_nxt;
        end
    end

    // Selected write strobe, rejected when both strobes low
    assign bus_wr = !bus.cs_n && !bus.wr_n && bus.rd_n && vcc_present;

    // Write enable
    always_comb begin
        mem_we = bus_wr;
    end

    // same path for clock bytes and extended RAM
    always_ff @(posedge mclk) begin
        if (mem_we) begin
            mem[addr_r[AW-1:0]] <= bus.shared_addr_data_bus;
        end
    end

    // Read data next value
    always_comb begin
        if (addr_r == `RTC_EXT_CTRL_ADDR) begin
            rdat_nxt = ctrl_r;
        end else begin
            rdat_nxt = mem[addr_r[AW-1:0]];
        end
    end

    // Read data register
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdat_r <= 8'h00;
        end else begin
            rdat_r <= rdat_nxt;
        end
    end

    // Shared bus drive
    always_comb begin
        bus.dev_ad_out = rdat_r;
        bus.dev_ad_oe  = !bus.cs_n && !bus.rd_n && bus.wr_n;
    end

    // Wake events only count while main supply is gone
    assign wake_evt = !vcc_present && (!kickstart_in_n || wake_alarm);

    // Control and power next values
    always_comb begin
        ctrl_nxt = ctrl_r;
        pwr_nxt  = pwr_r;
        xout_nxt = !crystal_in;
        // Software write to the control byte
        if (bus_wr && (addr_r == `RTC_EXT_CTRL_ADDR)) begin
            ctrl_nxt = bus.shared_addr_data_bus;
        end
        if (wake_evt) begin
            // wake raises power, set wins over clear
            pwr_nxt                     = 1'b1;
            ctrl_nxt[`RTC_PWR_KEEP_BIT] = 1'b1;
        end else if (vcc_present) begin
            pwr_nxt = ctrl_r[`RTC_PWR_KEEP_BIT];
        end
    end

    // Control and power registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_r <= `RTC_EXT_CTRL_RST;
            pwr_r  <= 1'b0;
            xout_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            pwr_r  <= pwr_nxt;
            xout_r <= xout_nxt;
        end
    end

    // Power pin drive
    always_comb begin
        bus.pwr_out = 1'b0;
        bus.pwr_oe  = pwr_r;
    end

    assign xtal_load_sel = ctrl_r[`RTC_XTAL_SEL_BIT];
    // Oscillator amplifier output
    assign crystal_out   = xout_r;
    // Power state seen by user side
    assign pwr_on_state  = pwr_r;
endmodule : rtc_dev_end

// ---- tb/rtc_chk.sv ----
// Pin relation checker for the RTC bus carrier.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module rtc_chk (
    input logic               mclk,
    input logic               rst,
    input rtc_pkg::rtc_byte_t host_ad_out,
    input logic               host_ad_oe,
    input logic               dev_ad_oe,
    input logic               ale,
    input logic               cs_n,
    input logic               rd_n,
    input logic               wr_n,
    input logic               pwr_out,
    input logic               pwr_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_pwr_pull_only: assert property (pwr_oe |-> !pwr_out)
        else $error("power pin driven high");
    a_ale_pulse_len: assert property ($rose(ale) |-> ale [*5] ##1 !ale)
        else $error("address strobe length wrong");
    a_addr_held: assert property ($fell(ale) |-> (host_ad_oe && $stable(host_ad_out)) [*2])
        else $error("address not held after strobe");
    a_addr_first: assert property ($fell(cs_n) |-> $past(ale, 3) && !$past(ale, 2))
        else $error("strobe not preceded by address");
    a_select_held: assert property ($fell(cs_n) |-> (!cs_n throughout (##19 1'b1)) ##1 cs_n)
        else $error("select not held through strobe");
    a_wdata_stable: assert property (!wr_n && !$past(wr_n) |-> host_ad_oe && $stable(host_ad_out))
        else $error("write data moved in strobe");
    a_rd_drive_win: assert property (dev_ad_oe == (!cs_n && !rd_n && wr_n))
        else $error("device drive outside read");
    a_rd_release: assert property ($rose(rd_n) |-> !dev_ad_oe)
        else $error("bus kept after read");
    a_no_clash: assert property (!(dev_ad_oe && host_ad_oe))
        else $error("both ends drive bus");
    a_strobe_excl: assert property (rd_n || wr_n)
        else $error("read and write strobes overlap");
    c_read: cover property ($fell(rd_n));
    c_write: cover property ($fell(wr_n));
    c_pwr_on: cover property ($rose(pwr_oe));
endmodule : rtc_chk

// ---- tb/rtc_muxed_bus_and_power_pins_tb.sv ----
// Bench: host end facing device end, plus a bench-driven second device end.
// Assumes design files and the constants header compile first.
`timescale 1ns/10ps
`include "rtc_params.svh"
module rtc_muxed_bus_and_power_pins_tb;
    logic               mclk, rst, req_valid, req_ready, req_write, rsp_valid, pwr_active;
    logic               vcc_present, kickstart_in_n, wake_alarm, crystal_in, xtal_load_sel, pwr_on_state;
    logic               crystal_out;  // Oscillator amplifier output
    rtc_pkg::rtc_byte_t req_addr, req_wdata, rsp_rdata, q, a;
    rtc_pkg::rtc_byte_t ref_mem [256];  // Expected memory image
    rtc_pkg::rtc_byte_t aq      [24];   // Addresses written
    int                 failures, num_checks;
    rtc_bus_if bus ();
    rtc_bus_if bus2 ();
    rtc_host_end rtc_host_end_i (.mclk, .rst, .bus(bus), .req_valid, .req_ready, .req_write, .req_addr,
        .req_wdata, .rsp_valid, .rsp_rdata, .pwr_active);
    rtc_dev_end rtc_dev_end_i (.mclk, .rst, .bus(bus), .vcc_present, .kickstart_in_n, .wake_alarm,
        .crystal_in, .crystal_out, .xtal_load_sel, .pwr_on_state);
    rtc_dev_end rtc_dev_end_i2 (.mclk, .rst, .bus(bus2), .vcc_present(1'b1), .kickstart_in_n(1'b1),
        .wake_alarm(1'b0), .crystal_in(1'b0), .crystal_out(), .xtal_load_sel(), .pwr_on_state());
    rtc_chk rtc_chk_i (.mclk, .rst, .host_ad_out(bus.host_ad_out), .host_ad_oe(bus.host_ad_oe),
        .dev_ad_oe(bus.dev_ad_oe), .ale(bus.ale), .cs_n(bus.cs_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
        .pwr_out(bus.pwr_out), .pwr_oe(bus.pwr_oe));
    // 125 MHz clock
    initial begin
        mclk = 0;
        forever #4 mclk = ~mclk;
    end
    function automatic rtc_pkg::rtc_byte_t expect_rd(input rtc_pkg::rtc_byte_t ad);
        return ref_mem[ad];
    endfunction : expect_rd
    task automatic chk8(input rtc_pkg::rtc_byte_t g, input rtc_pkg::rtc_byte_t e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk8
    task automatic chk1(input logic g, input logic e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk1
    task automatic summarize;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize
    // One user request, read data checked on the wire, timing and read data at the answer
    task automatic xfer(input logic w, input rtc_pkg::rtc_byte_t ad, input rtc_pkg::rtc_byte_t d);
        int n;
        n = 0;
        do @(negedge mclk); while (req_ready !== 1'b1);
        {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, ad, d};
        @(negedge mclk);
        req_valid = 0;
        repeat (8) @(negedge mclk);
        if (!w) chk8(bus.shared_addr_data_bus, expect_rd(ad));
        while (rsp_valid !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        if (n == 40) failures++;
        chk8(8'(n), 8'(`RTC_ALE_CYC + `RTC_AHOLD_CYC + `RTC_STRB_CYC - 8));
        if (!w) chk8(rsp_rdata, expect_rd(ad));
        if (w && vcc_present) ref_mem[ad] = d;
    endtask : xfer
    // Power pin, state and host view after settling
    task automatic pwr_chk(input logic on);
        repeat (3) @(negedge mclk);
        chk1(bus.power_on_out_n, !on);
        chk1(pwr_on_state, on);
        chk1(pwr_active, on);
    endtask : pwr_chk
    // Bench-made cycle on the second carrier, strobe levels as given
    task automatic raw(input rtc_pkg::rtc_byte_t ad, d, input logic c, r, w);
        @(negedge mclk);
        {bus2.ale, bus2.host_ad_oe, bus2.host_ad_out} = {2'b11, ad};
        repeat (5) @(negedge mclk);
        bus2.ale = 0;
        repeat (2) @(negedge mclk);
        {bus2.cs_n, bus2.rd_n, bus2.wr_n, bus2.host_ad_oe, bus2.host_ad_out} = {c, r, w, r, d};
        repeat (20) @(negedge mclk);
        q = bus2.shared_addr_data_bus;
        {bus2.cs_n, bus2.rd_n, bus2.wr_n, bus2.host_ad_oe} = 4'hE;
        repeat (3) @(negedge mclk);
    endtask : raw
    // Hang guard, about five times the expected run
    initial begin
        repeat (10000) @(posedge mclk);
        failures++;
        summarize();
    end
    initial begin
        {rst, req_valid, req_write, req_addr, req_wdata} = {1'b1, 18'h00000};
        {vcc_present, kickstart_in_n, wake_alarm, crystal_in} = 4'hC;
        {bus2.ale, bus2.cs_n, bus2.rd_n, bus2.wr_n, bus2.host_ad_oe, bus2.host_ad_out} = {5'h0E, 8'h00};
        failures = 0;
        num_checks = 0;
        void'($urandom(32'h25EE7023));
        repeat (12) @(negedge mclk);
        rst = 0;
        // random writes, edge addresses, back-to-back reads
        for (int i = 0; i < 24; i++) begin
            a = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            aq[i] = (a == `RTC_EXT_CTRL_ADDR) ? 8'h01 : a;
            crystal_in = 1'($urandom);
            xfer(1'b1, aq[i], 8'($urandom));
            chk1(crystal_out, !crystal_in);
        end
        for (int i = 0; i < 24; i++) xfer(1'b0, aq[i], 8'h00);
        xfer(1'b1, 8'h20, 8'h11);
        {vcc_present, kickstart_in_n} = 2'b00;
        @(negedge mclk);
        kickstart_in_n = 1;
        ref_mem[`RTC_EXT_CTRL_ADDR] = 8'h01;
        pwr_chk(1'b1);
        xfer(1'b1, 8'h20, 8'h99);
        vcc_present = 1;
        xfer(1'b1, `RTC_EXT_CTRL_ADDR, 8'h40);
        pwr_chk(1'b0);
        chk1(xtal_load_sel, 1'b1);
        xfer(1'b0, 8'h20, 8'h00);
        {vcc_present, wake_alarm} = 2'b01;
        @(negedge mclk);
        wake_alarm = 0;
        ref_mem[`RTC_EXT_CTRL_ADDR] = 8'h41;
        pwr_chk(1'b1);
        vcc_present = 1;
        xfer(1'b0, `RTC_EXT_CTRL_ADDR, 8'h00);
        xfer(1'b1, `RTC_EXT_CTRL_ADDR, 8'h00);
        pwr_chk(1'b0);
        chk1(xtal_load_sel, 1'b0);
        // Second carrier: overlap, unselected and proper cycles
        raw(8'h10, 8'h5A, 1'b0, 1'b1, 1'b0);
        raw(8'h10, 8'hA5, 1'b0, 1'b0, 1'b0);
        chk8(q, 8'hFF);
        raw(8'h10, 8'hC3, 1'b1, 1'b1, 1'b0);
        raw(8'h10, 8'h00, 1'b1, 1'b0, 1'b1);
        chk8(q, 8'hFF);
        raw(8'h10, 8'h00, 1'b0, 1'b0, 1'b1);
        chk8(q, 8'h5A);
        summarize();
    end
endmodule : rtc_muxed_bus_and_power_pins_tb
